// *** common/spd_cfg.svh ***
// Constants for the presence-detect memory and sensor serial target
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
`define SPD_PRE_SENS 4'h3
`define SPD_PRE_EE 4'hA
`define SPD_PRE_UT 4'h6
`define SPD_OP_BLK0 3'h1
`define SPD_OP_BLK1 3'h4
`define SPD_OP_BLK2 3'h5
`define SPD_OP_BLK3 3'h0
`define SPD_OP_CLR 3'h3
`define SPD_OP_BANK0 3'h6
`define SPD_OP_BANK1 3'h7
`define SPD_ERASED 8'hFF
`define SPD_PINS_RST 6'h30
`define SPD_CAP_VAL 16'h007F
// Identity words: arbitrary values
`define SPD_MFG_ID 16'hA5A5
`define SPD_DEV_ID 16'h5A01
`define SPD_TWR_MS 5
`define SPD_CLK_KHZ 25000
`endif

// *** common/spd_pkg.sv ***
// Types for the presence-detect memory and sensor serial target
package spd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } spd_state_t;
  typedef enum logic [1:0] {
    TGT_SENS = 2'b00,
    TGT_EE = 2'b01,
    TGT_UT = 2'b10,
    TGT_NONE = 2'b11
  } spd_tgt_t;
  typedef struct packed {
    spd_tgt_t tgt;
    logic [2:0] sel;
    logic rd;
  } spd_cmd_t;
  typedef struct packed {
    logic scl;
    logic sda;
    logic hv;
    logic [2:0] pins;
  } spd_pins_t;
endpackage

// *** rtl/spd_target.sv ***
// Serial target for the sensor registers and two-bank presence memory
`timescale 1ns/1ps
`include "spd_cfg.svh"
module spd_target import spd_pkg::*; #(
  parameter int WR_CYC = `SPD_TWR_MS * `SPD_CLK_KHZ
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset
  input wire logic i_scl, // Serial clock pin
  input wire logic i_sda, // Serial data pin level
  input wire logic [2:0] i_addr_pin, // Address pin states
  input wire logic i_overdrive_level, // Lowest pin at overdrive
  input wire logic [15:0] i_temp_data, // Measured temperature word
  output logic o_sda_out, // Data pin output value
  output logic o_sda_oe_n, // Data pin drive, low drives
  output logic o_busy, // Internal cycle running
  output logic o_bank, // Active memory bank
  output logic [3:0] o_protect // Block protect flags
);
  spd_pins_t pin_raw, s1_reg, s2_reg;
  logic scl_d_reg, sda_d_reg;
  logic rise, fall, start_ev, stop_ev, busy, byte_evt, ack_v;
  spd_state_t st_reg, st_next;
  spd_cmd_t cmd_reg, cmd_next;
  logic [7:0] sr_reg, sr_next, tx_reg, tx_next, out_byte;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] byte_reg, byte_next;
  logic ack_reg, ack_next, oe_n_reg, oe_n_next, half_reg, half_next;
  logic [2:0] sens_ptr_reg, sens_ptr_next, blk, nblk;
  logic [7:0] ee_ptr_reg, ee_ptr_next;
  logic [15:0] sens_wr_reg, sens_wr_next, sens_word;
  logic [15:0] sens_regs_reg [4];
  logic [15:0] sens_regs_next [4];
  logic bank_reg, bank_next, pend_reg, pend_next;
  logic [3:0] prot_reg, prot_next;
  logic [7:0] buf_reg [16];
  logic [7:0] buf_next [16];
  logic [15:0] mask_reg, mask_next;
  logic [16:0] wr_cnt_reg, wr_cnt_next;
  logic [4:0] wr_idx_reg, wr_idx_next, wr_page_reg, wr_page_next;
  logic [8:0] init_reg, init_next, mem_wa;
  logic init_done_reg, init_done_next, busy_reg, mem_we;
  logic [7:0] mem_wd;
  logic [7:0] mem [512];

  function automatic logic [2:0] blk_of(input logic [2:0] s);
    case (s)
      `SPD_OP_BLK0: blk_of = 3'h4;
      `SPD_OP_BLK1: blk_of = 3'h5;
      `SPD_OP_BLK2: blk_of = 3'h6;
      `SPD_OP_BLK3: blk_of = 3'h7;
      default: blk_of = 3'h0;
    endcase
  endfunction

  assign pin_raw = '{i_scl, i_sda, i_overdrive_level, i_addr_pin};
  // Pins pass two flops; the second stage and a delayed copy of its scl and sda are looked at
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= spd_pins_t'(`SPD_PINS_RST);
      s2_reg <= spd_pins_t'(`SPD_PINS_RST);
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      scl_d_reg <= s2_reg.scl;
      sda_d_reg <= s2_reg.sda;
    end
  end

  assign rise = s2_reg.scl & ~scl_d_reg;
  assign fall = ~s2_reg.scl & scl_d_reg;
  assign start_ev = s2_reg.scl & scl_d_reg & sda_d_reg & ~s2_reg.sda;
  assign stop_ev = s2_reg.scl & scl_d_reg & ~sda_d_reg & s2_reg.sda;
  assign busy = (wr_cnt_reg != 17'h0) | ~init_done_reg;
  assign byte_evt = (st_reg == ST_RX) & fall & (bit_reg == 4'h8);
  assign blk = blk_of(cmd_reg.sel);
  assign nblk = blk_of(sr_reg[3:1]);

  always_comb begin
    case (sens_ptr_reg)
      3'h0: sens_word = `SPD_CAP_VAL;
      3'h5: sens_word = i_temp_data;
      3'h6: sens_word = `SPD_MFG_ID;
      3'h7: sens_word = `SPD_DEV_ID;
      default: sens_word = sens_regs_reg[2'(sens_ptr_reg - 3'h1)];
    endcase
    case (cmd_reg.tgt)
      TGT_SENS: out_byte = half_reg ? sens_word[7:0] : sens_word[15:8];
      TGT_EE: out_byte = mem[{bank_reg, ee_ptr_reg}];
      default: out_byte = `SPD_ERASED;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    sr_next = sr_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    ack_next = ack_reg;
    oe_n_next = oe_n_reg;
    tx_next = tx_reg;
    sens_ptr_next = sens_ptr_reg;
    ee_ptr_next = ee_ptr_reg;
    half_next = half_reg;
    sens_wr_next = sens_wr_reg;
    sens_regs_next = sens_regs_reg;
    bank_next = bank_reg;
    prot_next = prot_reg;
    buf_next = buf_reg;
    mask_next = mask_reg;
    pend_next = pend_reg;
    wr_cnt_next = wr_cnt_reg;
    wr_idx_next = wr_idx_reg;
    wr_page_next = wr_page_reg;
    init_next = init_reg;
    init_done_next = init_done_reg;
    mem_we = 1'b0;
    mem_wa = 9'h0;
    mem_wd = `SPD_ERASED;
    ack_v = 1'b0;
    if (!init_done_reg) begin
      mem_we = 1'b1;
      mem_wa = init_reg;
      init_next = init_reg + 9'h1;
      init_done_next = (init_reg == 9'h1FF);
    end else if (wr_cnt_reg != 17'h0) begin
      wr_cnt_next = wr_cnt_reg - 17'h1;
      if (!wr_idx_reg[4]) begin
        mem_we = mask_reg[wr_idx_reg[3:0]];
        mem_wa = {wr_page_reg, wr_idx_reg[3:0]};
        mem_wd = buf_reg[wr_idx_reg[3:0]];
        wr_idx_next = wr_idx_reg + 5'h1;
      end
    end
    if (stop_ev) begin
      st_next = ST_IDLE;
      oe_n_next = 1'b1;
      pend_next = 1'b0;
      if (pend_reg) begin
        case (cmd_reg.tgt)
          TGT_SENS: begin
            if (sens_ptr_reg != 3'h0 && sens_ptr_reg < 3'h5) begin
              sens_regs_next[2'(sens_ptr_reg - 3'h1)] = sens_wr_reg;
            end
          end
          TGT_EE: begin
            wr_cnt_next = 17'(WR_CYC);
            wr_idx_next = 5'h0;
            wr_page_next = {bank_reg, ee_ptr_reg[7:4]};
          end
          TGT_UT: begin
            // flag change takes a write cycle
            if (cmd_reg.sel == `SPD_OP_CLR) begin
              prot_next = 4'h0;
            end else begin
              prot_next[blk[1:0]] = 1'b1;
            end
            wr_cnt_next = 17'(WR_CYC);
            wr_idx_next = 5'h10;
          end
          default: ;
        endcase
      end
    end else if (start_ev) begin
      st_next = ST_RX;
      bit_next = 4'h0;
      byte_next = 2'h0;
      oe_n_next = 1'b1;
      pend_next = 1'b0;
      // Buffer is still being copied while busy
      if (!busy) begin
        mask_next = 16'h0;
      end
    end else begin
      case (st_reg)
        ST_RX: begin
          if (rise) begin
            sr_next = {sr_reg[6:0], s2_reg.sda};
            bit_next = bit_reg + 4'h1;
          end else if (byte_evt) begin
            if (byte_reg == 2'h0) begin
              cmd_next.sel = sr_reg[3:1];
              cmd_next.rd = sr_reg[0];
              half_next = 1'b0;
              case (sr_reg[7:4])
                `SPD_PRE_SENS: begin
                  cmd_next.tgt = TGT_SENS;
                  ack_v = (sr_reg[3:1] == s2_reg.pins);
                end
                `SPD_PRE_EE: begin
                  cmd_next.tgt = TGT_EE;
                  ack_v = (sr_reg[3:1] == s2_reg.pins);
                end
                `SPD_PRE_UT: begin
                  cmd_next.tgt = TGT_UT;
                  // query and set answer by flag
                  if (nblk[2]) begin
                    ack_v = ~prot_reg[nblk[1:0]];
                  end else if (sr_reg[0]) begin
                    ack_v = (sr_reg[3:1] == `SPD_OP_BANK0) & ~bank_reg;
                  end else begin
                    ack_v = (sr_reg[3:1] == `SPD_OP_CLR) |
                            (sr_reg[3:2] == 2'h3);
                  end
                end
                default: cmd_next.tgt = TGT_NONE;
              endcase
              if (busy) begin
                ack_v = 1'b0;
              end
            end else if (byte_reg == 2'h1) begin
              ack_v = 1'b1;
              if (cmd_reg.tgt == TGT_SENS) begin
                sens_ptr_next = sr_reg[2:0];
              end
              if (cmd_reg.tgt == TGT_EE) begin
                ee_ptr_next = sr_reg;
              end
            end else begin
              case (cmd_reg.tgt)
                TGT_SENS: begin
                  ack_v = ~((byte_reg == 2'h3) & pend_reg);
                  if (byte_reg == 2'h2) begin
                    sens_wr_next[15:8] = sr_reg;
                  end else if (ack_v) begin
                    sens_wr_next[7:0] = sr_reg;
                    pend_next = 1'b1;
                  end
                end
                TGT_EE: begin
                  // block is bank plus top address bit
                  ack_v = ~prot_reg[{bank_reg, ee_ptr_reg[7]}];
                  if (ack_v) begin
                    buf_next[ee_ptr_reg[3:0]] = sr_reg;
                    mask_next[ee_ptr_reg[3:0]] = 1'b1;
                    ee_ptr_next[3:0] = ee_ptr_reg[3:0] + 4'h1;
                    pend_next = 1'b1;
                  end
                end
                TGT_UT: begin
                  if (blk[2] || cmd_reg.sel == `SPD_OP_CLR) begin
                    ack_v = s2_reg.hv;
                    pend_next = s2_reg.hv;
                  end else begin
                    bank_next = cmd_reg.sel[0];
                  end
                end
                default: ;
              endcase
            end
            byte_next = (byte_reg == 2'h3) ? 2'h3 : byte_reg + 2'h1;
            bit_next = 4'h0;
            ack_next = ack_v;
            oe_n_next = ~ack_v;
            st_next = ST_ACK;
          end
        end
        ST_ACK: begin
          if (fall) begin
            oe_n_next = 1'b1;
            if (!ack_reg) begin
              st_next = ST_IDLE;
            end else if (cmd_reg.rd) begin
              st_next = ST_TX;
              bit_next = 4'h0;
              oe_n_next = out_byte[7];
              tx_next = {out_byte[6:0], 1'b0};
            end else begin
              st_next = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bit_reg == 4'h7) begin
              oe_n_next = 1'b1;
              st_next = ST_MACK;
              half_next = ~half_reg;
              ee_ptr_next = (cmd_reg.tgt == TGT_EE) ?
                            ee_ptr_reg + 8'h1 : ee_ptr_reg;
            end else begin
              oe_n_next = tx_reg[7];
              tx_next = {tx_reg[6:0], 1'b0};
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            ack_next = ~s2_reg.sda;
            st_next = ST_ACK;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  // Array left unreset; erased by the power-up sweep instead
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= ST_IDLE;
      cmd_reg <= '{TGT_NONE, 3'h0, 1'b0};
      sr_reg <= 8'h00;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      ack_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      tx_reg <= 8'h00;
      sens_ptr_reg <= 3'h0;
      ee_ptr_reg <= 8'h00;
      half_reg <= 1'b0;
      sens_wr_reg <= 16'h0000;
      sens_regs_reg <= '{default: 16'h0000};
      bank_reg <= 1'b0;
      prot_reg <= 4'h0;
      buf_reg <= '{default: 8'h00};
      mask_reg <= 16'h0000;
      pend_reg <= 1'b0;
      wr_cnt_reg <= 17'h0;
      wr_idx_reg <= 5'h10;
      wr_page_reg <= 5'h0;
      init_reg <= 9'h0;
      init_done_reg <= 1'b0;
      busy_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      sr_reg <= sr_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      ack_reg <= ack_next;
      oe_n_reg <= oe_n_next;
      tx_reg <= tx_next;
      sens_ptr_reg <= sens_ptr_next;
      ee_ptr_reg <= ee_ptr_next;
      half_reg <= half_next;
      sens_wr_reg <= sens_wr_next;
      sens_regs_reg <= sens_regs_next;
      bank_reg <= bank_next;
      prot_reg <= prot_next;
      buf_reg <= buf_next;
      mask_reg <= mask_next;
      pend_reg <= pend_next;
      wr_cnt_reg <= wr_cnt_next;
      wr_idx_reg <= wr_idx_next;
      wr_page_reg <= wr_page_next;
      init_reg <= init_next;
      init_done_reg <= init_done_next;
      busy_reg <= (wr_cnt_next != 17'h0) | ~init_done_next;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = oe_n_reg;
  assign o_busy = busy_reg;
  assign o_bank = bank_reg;
  assign o_protect = prot_reg;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence ee_commit_s;
    stop_ev && pend_reg && cmd_reg.tgt == TGT_EE;
  endsequence
  busy_addr_nack_a: assert property (
    byte_evt && byte_reg == 2'h0 && busy |=> oe_n_reg && st_reg == ST_ACK)
    else $error("address acknowledged while busy");
  ee_commit_a: assert property (
    ee_commit_s |=> wr_cnt_reg == 17'(WR_CYC) ##1 wr_idx_reg == 5'h1)
    else $error("page write cycle not started");
  page_wrap_a: assert property (
    byte_evt && byte_reg[1] && cmd_reg.tgt == TGT_EE && ack_v
    |=> ee_ptr_reg[3:0] == $past(ee_ptr_reg[3:0]) + 4'h1 &&
        ee_ptr_reg[7:4] == $past(ee_ptr_reg[7:4]))
    else $error("page pointer step wrong");
  bank_wrap_a: assert property (
    st_reg == ST_TX && fall && bit_reg == 4'h7 &&
    cmd_reg.tgt == TGT_EE && ee_ptr_reg == 8'hFF |=> ee_ptr_reg == 8'h00)
    else $error("read pointer did not wrap");
  bank_query_a: assert property (
    byte_evt && byte_reg == 2'h0 && !busy && sr_reg == 8'h6D
    |=> oe_n_reg == $past(bank_reg))
    else $error("bank query answer wrong");
  no_overdrive_a: assert property (
    byte_evt && byte_reg == 2'h2 && cmd_reg.tgt == TGT_UT && blk[2] &&
    !s2_reg.hv |=> oe_n_reg && !pend_reg ##1 prot_reg == $past(prot_reg, 2))
    else $error("flag change without overdrive");
  bank_sel_a: assert property (
    byte_evt && byte_reg == 2'h2 && cmd_reg.tgt == TGT_UT &&
    cmd_reg.sel[2:1] == 2'h3 |=> oe_n_reg && bank_reg == cmd_reg.sel[0] &&
    !pend_reg)
    else $error("bank select handling wrong");
  prot_nack_a: assert property (
    byte_evt && byte_reg == 2'h0 && sr_reg[7:4] == `SPD_PRE_UT &&
    nblk[2] && prot_reg[nblk[1:0]] |=> oe_n_reg [*2])
    else $error("protected block acknowledged");
endmodule

// *** tb/spd_master_model.sv ***
// Bus master model driving the serial clock and data lines
`timescale 1ns/1ps
module spd_master_model (
  input wire logic i_clk, // System clock
  input wire logic i_sda, // Resolved data wire
  output logic o_scl, // Serial clock drive
  output logic o_sda // Data drive, 1 releases
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Low phase 5 clocks so the target answer settles first
  task automatic bit_io(input logic b, output logic r);
    o_scl <= 1'b0;
    tick(3);
    o_sda <= b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(1);
  endtask
  // Start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic a, input logic b);
    o_scl <= 1'b0;
    tick(3);
    o_sda <= a;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda <= b;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, r);
  endtask
endmodule

// *** tb/tb_spd_target.sv ***
// Self-checking bench for the serial target
`timescale 1ns/1ps
`include "spd_cfg.svh"
module tb_spd_target;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [15:0] TEMP = 16'hC3A1;
  logic clk, rst, scl, m_sda, sda_w, ovd, sda_out, oe_n, busy, bank;
  logic [2:0] pins;
  logic [15:0] temp;
  logic [3:0] prot;
  int miscompares, n_compared;
  // Third byte is refused but the first two still land at stop
  logic [15:0] ex[4] = '{`SPD_CAP_VAL, 16'hABCD, 16'h1122, TEMP};
  logic [7:0] rg[4] = '{8'h00, 8'h01, 8'h02, 8'h05};
  logic [2:0] blk[4] = '{`SPD_OP_BLK0, `SPD_OP_BLK1, `SPD_OP_BLK2,
    `SPD_OP_BLK3};
  // Open-drain wire with pull-up
  assign sda_w = m_sda & (oe_n | sda_out);
  spd_master_model i_spd_master_model (.i_clk(clk), .i_sda(sda_w),
    .o_scl(scl), .o_sda(m_sda));
  spd_target #(.WR_CYC(200)) i_spd_target (.i_clk(clk), .i_rst(rst),
    .i_scl(scl), .i_sda(sda_w), .i_addr_pin(pins),
    .i_overdrive_level(ovd), .i_temp_data(temp), .o_sda_out(sda_out),
    .o_sda_oe_n(oe_n), .o_busy(busy), .o_bank(bank), .o_protect(prot));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] ee(input logic r);
    return {`SPD_PRE_EE, PINS, r};
  endfunction
  function automatic logic [7:0] sens(input logic r);
    return {`SPD_PRE_SENS, PINS, r};
  endfunction
  function automatic logic [7:0] ut(input logic [2:0] c, input logic r);
    return {`SPD_PRE_UT, c, r};
  endfunction
  task automatic send(input logic [7:0] b[$], input bit stp,
                      output logic [31:0] ak);
    logic a;
    ak = '0;
    i_spd_master_model.cond(1'b1, 1'b0);
    foreach (b[i]) begin
      i_spd_master_model.put_byte(b[i], a);
      ak[i] = a;
    end
    if (stp) i_spd_master_model.cond(1'b0, 1'b1);
  endtask
  task automatic rdn(input int n, output logic [7:0] d[$]);
    logic [7:0] v;
    d = {};
    for (int i = 0; i < n; i++) begin
      i_spd_master_model.get_byte(i < n - 1, v);
      d.push_back(v);
    end
    i_spd_master_model.cond(1'b0, 1'b1);
  endtask
  task automatic sel_rd(input logic [7:0] w, input logic [7:0] p,
                        input int n, output logic [7:0] d[$]);
    logic [31:0] ak;
    send({w, p}, 0, ak);
    send({w | 8'h01}, 0, ak);
    rdn(n, d);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (6) @(posedge clk);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(busy, 1'b0);
  endtask
  initial begin
    #2000000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    logic [31:0] ak;
    logic [7:0] d[$];
    logic [7:0] q[$];
    rst = 1'b1;
    ovd = 1'b0;
    pins = PINS;
    temp = TEMP;
    repeat (16) @(posedge clk);
    check({busy, bank, prot}, 6'h20);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    send({ee(1'b0)}, 1, ak);
    check(ak[0], 1'b0);
    wait_idle;
    send({ee(1'b1)}, 0, ak);
    rdn(2, d);
    check({ak[0], d[0], d[1]}, 17'h1FFFF);
    send({ee(1'b0), 8'h00, 8'h3C}, 1, ak);
    check(ak, 32'h7);
    repeat (6) @(posedge clk);
    check(busy, 1'b1);
    send({ee(1'b1)}, 1, ak);
    check(ak[0], 1'b0);
    wait_idle;
    q = {ee(1'b0), 8'h2E};
    for (int i = 0; i < 18; i++) q.push_back(8'(i));
    send(q, 1, ak);
    check(ak, 32'hFFFFF);
    wait_idle;
    sel_rd(ee(1'b0), 8'h20, 17, d);
    for (int k = 0; k < 17; k++) begin
      check(d[k], (k < 16) ? 8'(k + 2) : `SPD_ERASED);
    end
    sel_rd(ee(1'b0), 8'hFF, 2, d);
    check({d[0], d[1]}, 16'hFF3C);
    send({sens(1'b0), 8'h01, 8'hAB, 8'hCD}, 1, ak);
    check(ak, 32'hF);
    repeat (8) @(posedge clk);
    check(busy, 1'b0);
    send({sens(1'b0), 8'h02, 8'h11, 8'h22, 8'h33}, 1, ak);
    check(ak, 32'hF);
    for (int i = 0; i < 4; i++) begin
      sel_rd(sens(1'b0), rg[i], 2, d);
      check({d[0], d[1]}, ex[i]);
    end
    send({{`SPD_PRE_SENS, ~PINS, 1'b1}}, 1, ak);
    check(ak[0], 1'b0);
    send({ut(`SPD_OP_BANK0, 1'b1)}, 0, ak);
    rdn(1, d);
    check({ak[0], d[0]}, 9'h1FF);
    send({ut(`SPD_OP_BANK1, 1'b0), 8'h00, 8'h00}, 1, ak);
    repeat (8) @(posedge clk);
    check({ak[2:0], bank, busy}, 5'hE);
    send({ut(`SPD_OP_BANK0, 1'b1)}, 1, ak);
    check(ak[0], 1'b0);
    sel_rd(ee(1'b0), 8'h00, 1, d);
    check(d[0], `SPD_ERASED);
    send({ut(`SPD_OP_BANK0, 1'b0), 8'h00, 8'h00}, 1, ak);
    check(bank, 1'b0);
    send({ut(`SPD_OP_BLK0, 1'b0), 8'h00, 8'h00}, 1, ak);
    check({ak[2:0], prot}, 7'h30);
    for (int i = 0; i < 4; i++) begin
      send({ut(blk[i], 1'b1)}, 0, ak);
      rdn(1, d);
      check(ak[0], 1'b1);
      ovd <= 1'b1;
      @(posedge clk);
      send({ut(blk[i], 1'b0), 8'h00, 8'h00}, 1, ak);
      wait_idle;
      ovd <= 1'b0;
      check({ak[2:0], prot}, {3'h7, 4'((1 << (i + 1)) - 1)});
      send({ut(blk[i], 1'b1)}, 1, ak);
      check(ak[0], 1'b0);
      if (i == 0) begin
        send({ee(1'b0), 8'h7F, 8'h11}, 1, ak);
        check(ak, 32'h3);
        send({ee(1'b0), 8'h80, 8'h5A}, 1, ak);
        check(ak, 32'h7);
        wait_idle;
        sel_rd(ee(1'b0), 8'h7F, 2, d);
        check({d[0], d[1]}, 16'hFF5A);
      end
    end
    ovd <= 1'b1;
    @(posedge clk);
    send({ut(`SPD_OP_BLK0, 1'b0), 8'h00, 8'h00}, 1, ak);
    repeat (8) @(posedge clk);
    check({ak[2:0], busy}, 4'h0);
    send({ut(`SPD_OP_CLR, 1'b0), 8'h00, 8'h00}, 1, ak);
    wait_idle;
    ovd <= 1'b0;
    check({ak[2:0], prot}, 7'h70);
    report_and_stop;
  end
endmodule
